//--- logic/csbm_pkg.sv
/*
 * Shared constants and types for the camera settings bank manager.
 * Assumes a word-addressed non-volatile memory port on the same clock.
 */
`default_nettype none
package csbm_pkg;
	localparam int CSBM_NPARAM = 37;
	localparam int CSBM_WORD_W = 32;
	localparam int CSBM_ADDR_W = 8;
	localparam int CSBM_IDX_W = 6;

	typedef enum logic [1:0] {
		CSBM_BANK_FACTORY = 2'h0,
		CSBM_BANK_ONE = 2'h1,
		CSBM_BANK_TWO = 2'h2,
		CSBM_BANK_THREE = 2'h3
	} csbm_bank_t;

	// Covered parameter slots, one word each, in bank order
	typedef enum logic [CSBM_IDX_W-1:0] {
		CSBM_P_WIDTH = 6'h00, CSBM_P_HEIGHT = 6'h01, CSBM_P_OFFSET_X = 6'h02,
		CSBM_P_OFFSET_Y = 6'h03, CSBM_P_DECIM_H = 6'h04, CSBM_P_DECIM_V = 6'h05,
		CSBM_P_REVERSE_X = 6'h06, CSBM_P_REVERSE_Y = 6'h07, CSBM_P_PIX_FMT = 6'h08,
		CSBM_P_ACQ_MODE = 6'h09, CSBM_P_FRAME_RATE = 6'h0a, CSBM_P_TRIG_MODE = 6'h0b,
		CSBM_P_TRIG_SRC = 6'h0c, CSBM_P_TRIG_ACT = 6'h0d, CSBM_P_TRIG_DELAY = 6'h0e,
		CSBM_P_TRIG_SAMPLE = 6'h0f, CSBM_P_EXP_MODE = 6'h10, CSBM_P_EXP_TIME = 6'h11,
		CSBM_P_EXP_AUTO = 6'h12, CSBM_P_LINE_INV = 6'h13, CSBM_P_LINE_SRC = 6'h14,
		CSBM_P_TMR_DUR = 6'h15, CSBM_P_TMR_DELAY = 6'h16, CSBM_P_TMR_TRIG = 6'h17,
		CSBM_P_GAIN = 6'h18, CSBM_P_GAIN_AUTO = 6'h19, CSBM_P_BLACK = 6'h1a,
		CSBM_P_GAMMA = 6'h1b, CSBM_P_ALP_AREA = 6'h1c, CSBM_P_ALP_REF = 6'h1d,
		CSBM_P_ALP_EV = 6'h1e, CSBM_P_ALP_TOL = 6'h1f, CSBM_P_ALP_THROT = 6'h20,
		CSBM_P_ALP_EXP_MIN = 6'h21, CSBM_P_ALP_EXP_MAX = 6'h22,
		CSBM_P_ALP_GAIN_MIN = 6'h23, CSBM_P_ALP_GAIN_MAX = 6'h24
	} csbm_param_t;

	// Boot selector word sits after the four banks
	localparam logic [CSBM_ADDR_W-1:0] CSBM_BOOT_ADDR = 8'h94;
	localparam int CSBM_BOOT_VALID_BIT = 2;
	localparam logic [CSBM_WORD_W-1:0] CSBM_PARAM_RESET = 32'h0000_0000;

	typedef struct packed {
		logic req;
		logic we;
		logic [CSBM_ADDR_W-1:0] addr;
		logic [CSBM_WORD_W-1:0] wdata;
	} csbm_nvm_req_t;

	typedef struct packed {
		logic ack;
		logic [CSBM_WORD_W-1:0] rdata;
	} csbm_nvm_rsp_t;
endpackage : csbm_pkg
`default_nettype wire

//--- logic/csbm_bank_manager.sv
/*
 * Camera settings bank manager: live parameter set, bank select, restore,
 * store and boot-time restore against a word-wide non-volatile memory.
 * Assumes the memory answers each request with a one-cycle ack on sys_clk
 * and that host ports and stream_active come from logic on sys_clk.
 */
// Function
// - Three writable banks plus one factory bank, each a full parameter copy.
// - Bank selector holds factory or banks one to three, read/write, targets both commands.
// - Bank selector resets to the factory bank.
// - Factory bank is restore-only; a store aimed at it is refused.
// - Restore reads the selected bank and applies every covered parameter.
// - Store copies the applied parameters into the selected writable bank.
// - Restore and store are write-only pulse triggers with no readable value.
// - At power-up the stored boot bank is restored if a valid selector exists.
// - Boot bank selector is a read/write enumeration choosing the power-up bank once a store saves it.
// - Restore while the image stream is running is ignored.
// - Banks cover geometry, format, trigger, exposure, IO, timer, gain and light params.
`timescale 1ns/1ps
`default_nettype none
module csbm_bank_manager
	import csbm_pkg::*;
#(
	parameter int NPARAM = CSBM_NPARAM
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic stream_active,
	input wire logic bank_select_we,
	input wire csbm_bank_t bank_select_wdata,
	output csbm_bank_t bank_select,
	input wire logic boot_bank_select_we,
	input wire csbm_bank_t boot_bank_select_wdata,
	output csbm_bank_t boot_bank_select,
	input wire logic bank_restore_cmd,
	input wire logic bank_store_cmd,
	input wire logic param_we,
	input wire logic [CSBM_IDX_W-1:0] param_idx,
	input wire logic [CSBM_WORD_W-1:0] param_wdata,
	output logic [CSBM_WORD_W-1:0] param_rdata,
	output logic [NPARAM*CSBM_WORD_W-1:0] live_params,
	output logic busy,
	output logic cmd_done,
	output logic cmd_refused,
	output csbm_nvm_req_t nvm_req,
	input wire csbm_nvm_rsp_t nvm_rsp
);
	if (NPARAM != CSBM_NPARAM || NPARAM > (1 << CSBM_IDX_W)) begin : g_chk
		$error("NPARAM must equal the covered parameter count");
	end

	typedef enum logic [2:0] {
		CSBM_S_BOOT = 3'b000,
		CSBM_S_IDLE = 3'b001,
		CSBM_S_READ = 3'b011,
		CSBM_S_APPLY = 3'b010,
		CSBM_S_WRITE = 3'b110,
		CSBM_S_COMMIT = 3'b111
	} csbm_state_t;

	function automatic logic [CSBM_ADDR_W-1:0] csbm_addr(input csbm_bank_t b,
			input logic [CSBM_IDX_W-1:0] i);
		logic [CSBM_ADDR_W-1:0] base;
		base = CSBM_ADDR_W'(b) * CSBM_ADDR_W'(NPARAM);
		return base + CSBM_ADDR_W'(i);
	endfunction : csbm_addr

	localparam logic [CSBM_IDX_W-1:0] LAST_IDX = CSBM_IDX_W'(NPARAM - 1);

	csbm_state_t state_q;
	csbm_bank_t target_q;
	logic [CSBM_IDX_W-1:0] idx_q;
	logic boot_phase_q;
	logic [CSBM_WORD_W-1:0] live_q [NPARAM];
	logic [CSBM_WORD_W-1:0] shadow_q [NPARAM];
	logic restore_ok;
	logic store_ok;
	logic idle;

	assign idle = (state_q == CSBM_S_IDLE);
	assign busy = !idle;
	assign restore_ok = idle && bank_restore_cmd && !stream_active;
	// Restore takes priority when both triggers arrive together
	assign store_ok = idle && bank_store_cmd && !bank_restore_cmd
		&& (bank_select != CSBM_BANK_FACTORY);

	// Triggers are taken as pulses and never stored as a readable value
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cmd_refused <= 1'b0;
		end else begin
			cmd_refused <= (bank_restore_cmd && !restore_ok)
				|| (bank_store_cmd && !bank_restore_cmd && !store_ok);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bank_select <= CSBM_BANK_FACTORY;
		end else if (bank_select_we) begin
			bank_select <= bank_select_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			boot_bank_select <= CSBM_BANK_FACTORY;
		end else if (state_q == CSBM_S_BOOT && nvm_rsp.ack
				&& nvm_rsp.rdata[CSBM_BOOT_VALID_BIT]) begin
			boot_bank_select <= csbm_bank_t'(nvm_rsp.rdata[1:0]);
		end else if (boot_bank_select_we && state_q != CSBM_S_COMMIT) begin
			// Held off during commit so the word being written stays stable
			boot_bank_select <= boot_bank_select_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q <= CSBM_S_BOOT;
			target_q <= CSBM_BANK_FACTORY;
			idx_q <= '0;
			boot_phase_q <= 1'b1;
		end else begin
			unique case (state_q)
				CSBM_S_BOOT: begin
					if (nvm_rsp.ack) begin
						boot_phase_q <= nvm_rsp.rdata[CSBM_BOOT_VALID_BIT];
						target_q <= csbm_bank_t'(nvm_rsp.rdata[1:0]);
						idx_q <= '0;
						// No stored selector: keep reset values
						state_q <= nvm_rsp.rdata[CSBM_BOOT_VALID_BIT]
							? CSBM_S_READ : CSBM_S_IDLE;
					end
				end
				CSBM_S_IDLE: begin
					boot_phase_q <= 1'b0;
					idx_q <= '0;
					target_q <= bank_select;
					if (restore_ok) begin
						state_q <= CSBM_S_READ;
					end else if (store_ok) begin
						state_q <= CSBM_S_WRITE;
					end
				end
				CSBM_S_READ: begin
					if (nvm_rsp.ack) begin
						if (idx_q == LAST_IDX) begin
							state_q <= CSBM_S_APPLY;
						end else begin
							idx_q <= idx_q + 1'b1;
						end
					end
				end
				CSBM_S_APPLY: begin
					state_q <= CSBM_S_IDLE;
				end
				CSBM_S_WRITE: begin
					if (nvm_rsp.ack) begin
						if (idx_q == LAST_IDX) begin
							state_q <= CSBM_S_COMMIT;
						end else begin
							idx_q <= idx_q + 1'b1;
						end
					end
				end
				CSBM_S_COMMIT: begin
					if (nvm_rsp.ack) begin
						state_q <= CSBM_S_IDLE;
					end
				end
				default: begin
					state_q <= CSBM_S_IDLE;
				end
			endcase
		end
	end

	// Words gather in a shadow so a restore never leaves a half-applied set
	always_ff @(posedge sys_clk) begin
		if (state_q == CSBM_S_READ && nvm_rsp.ack) begin
			shadow_q[idx_q] <= nvm_rsp.rdata;
		end
	end

	// Host edits are held off while busy so a store copies one coherent set
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NPARAM; i++) begin
				live_q[i] <= CSBM_PARAM_RESET;
			end
		end else if (state_q == CSBM_S_APPLY) begin
			for (int i = 0; i < NPARAM; i++) begin
				live_q[i] <= shadow_q[i];
			end
		end else if (idle && param_we && param_idx <= LAST_IDX) begin
			live_q[param_idx] <= param_wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			param_rdata <= '0;
		end else if (param_idx <= LAST_IDX) begin
			param_rdata <= live_q[param_idx];
		end else begin
			param_rdata <= '0;
		end
	end

	always_comb begin
		for (int i = 0; i < NPARAM; i++) begin
			live_params[i*CSBM_WORD_W +: CSBM_WORD_W] = live_q[i];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cmd_done <= 1'b0;
		end else begin
			cmd_done <= (state_q == CSBM_S_APPLY && !boot_phase_q)
				|| (state_q == CSBM_S_COMMIT && nvm_rsp.ack);
		end
	end

	// Request is held until ack; the memory must not ack without a request
	always_comb begin
		nvm_req = '0;
		unique case (state_q)
			CSBM_S_BOOT: begin
				nvm_req.req = 1'b1;
				nvm_req.addr = CSBM_BOOT_ADDR;
			end
			CSBM_S_READ: begin
				nvm_req.req = 1'b1;
				nvm_req.addr = csbm_addr(target_q, idx_q);
			end
			CSBM_S_WRITE: begin
				nvm_req.req = 1'b1;
				nvm_req.we = 1'b1;
				nvm_req.addr = csbm_addr(target_q, idx_q);
				nvm_req.wdata = live_q[idx_q];
			end
			CSBM_S_COMMIT: begin
				// Boot selector rides on each store and lands last
				nvm_req.req = 1'b1;
				nvm_req.we = 1'b1;
				nvm_req.addr = CSBM_BOOT_ADDR;
				nvm_req.wdata = {{(CSBM_WORD_W-3){1'b0}}, 1'b1, boot_bank_select};
			end
			default: begin
				nvm_req = '0;
			end
		endcase
	end
endmodule : csbm_bank_manager
`default_nettype wire

//--- bench/csbm_monitor.sv
/* Port checker for the settings bank manager.
 * Assumes it is bound to csbm_bank_manager on one clock. */
`timescale 1ns/1ps
`default_nettype none
module csbm_monitor
	import csbm_pkg::*;
#(
	parameter int NPARAM = CSBM_NPARAM
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic stream_active,
	input wire logic bank_select_we,
	input wire csbm_bank_t bank_select_wdata,
	input wire csbm_bank_t bank_select,
	input wire csbm_bank_t boot_bank_select,
	input wire logic bank_restore_cmd,
	input wire logic bank_store_cmd,
	input wire logic [NPARAM*CSBM_WORD_W-1:0] live_params,
	input wire logic busy,
	input wire logic cmd_done,
	input wire logic cmd_refused,
	input wire csbm_nvm_req_t nvm_req,
	input wire csbm_nvm_rsp_t nvm_rsp
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic go_r;
	logic go_s;
	assign go_r = bank_restore_cmd && !busy;
	assign go_s = bank_store_cmd && !bank_restore_cmd && !busy;
	a_sel_write: assert property (bank_select_we && !busy |=>
		bank_select == $past(bank_select_wdata)) else $error("select write lost");
	a_store_refuse: assert property (go_s && bank_select == CSBM_BANK_FACTORY |=>
		cmd_refused) else $error("factory store not refused");
	a_factory_safe: assert property (nvm_req.req && nvm_req.we |->
		nvm_req.addr > 8'h24) else $error("factory bank written");
	a_restore_start: assert property (go_r && !stream_active |=> busy &&
		!nvm_req.we && nvm_req.addr == 8'($past(bank_select)) * 8'h25) else $error("bad restore");
	a_store_start: assert property (go_s && bank_select != CSBM_BANK_FACTORY |=>
		nvm_req.we && nvm_req.addr == 8'($past(bank_select)) * 8'h25) else $error("bad store");
	a_done_pulse: assert property (cmd_done |=> !cmd_done)
		else $error("done not a pulse");
	a_stream_block: assert property (go_r && stream_active |=> cmd_refused &&
		$stable(live_params)) else $error("restore ran while streaming");
	a_commit_word: assert property (nvm_req.req && nvm_req.we && nvm_req.addr == CSBM_BOOT_ADDR
		|-> nvm_req.wdata == {29'h0, 1'b1, boot_bank_select}) else $error("bad commit word");
	a_restore_bound: assert property (go_r && !stream_active |-> ##[39:600] cmd_done)
		else $error("restore never done");
	a_req_hold: assert property (nvm_req.req && !nvm_rsp.ack |=> $stable(nvm_req))
		else $error("request dropped");
	cover property (cmd_done);
	cover property (cmd_refused);
	cover property (go_s && bank_select != CSBM_BANK_FACTORY);
endmodule : csbm_monitor
bind csbm_bank_manager csbm_monitor #(.NPARAM(NPARAM)) csbm_monitor_inst (.*);
`default_nettype wire

//--- bench/csbm_nvm_model.sv
/* Behavioural non-volatile memory holding the setting banks.
 * Assumes the manager holds each request until its ack. */
`timescale 1ns/1ps
`default_nettype none
module csbm_nvm_model
	import csbm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic slow,
	input wire csbm_nvm_req_t nvm_req,
	output csbm_nvm_rsp_t nvm_rsp
);
	logic [CSBM_WORD_W-1:0] mem [256];
	logic [1:0] wait_q;
	initial begin
		foreach (mem[i]) mem[i] = (i < CSBM_NPARAM) ? 32'hf000_0000 + i : 32'h0;
		nvm_rsp = '0;
		wait_q = 2'h0;
	end
	// Slow mode stalls each word so the manager must wait on ack
	always @(posedge sys_clk) begin
		if (nvm_req.req && !nvm_rsp.ack && (wait_q == 2'h3 || !slow)) begin
			nvm_rsp.ack <= 1'b1;
			nvm_rsp.rdata <= mem[nvm_req.addr];
			if (nvm_req.we) mem[nvm_req.addr] <= nvm_req.wdata;
			wait_q <= 2'h0;
		end else begin
			nvm_rsp.ack <= 1'b0;
			nvm_rsp.rdata <= ~nvm_rsp.rdata; // Stale data never looks valid
			wait_q <= nvm_req.req ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule : csbm_nvm_model
`default_nettype wire

//--- bench/csbm_bank_manager_tb.sv
/* Self-checking bench for the settings bank manager.
 * Assumes the behavioural memory model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module csbm_bank_manager_tb;
	import csbm_pkg::*;
	localparam int LW = CSBM_NPARAM * CSBM_WORD_W;
	logic sys_clk = 1'b0, reset = 1'b1, stream_active = 1'b0, slow = 1'b0;
	logic bank_select_we = 1'b0, boot_bank_select_we = 1'b0, param_we = 1'b0;
	logic bank_restore_cmd = 1'b0, bank_store_cmd = 1'b0;
	csbm_bank_t bank_select_wdata = CSBM_BANK_FACTORY, boot_bank_select_wdata = CSBM_BANK_FACTORY;
	csbm_bank_t bank_select, boot_bank_select;
	logic [CSBM_IDX_W-1:0] param_idx = '0;
	logic [CSBM_WORD_W-1:0] param_wdata = '0, param_rdata;
	logic [LW-1:0] live_params, live_exp, bank_exp [4];
	logic busy, cmd_done, cmd_refused;
	csbm_nvm_req_t nvm_req;
	csbm_nvm_rsp_t nvm_rsp;
	logic [LW:0] exp_q [$];
	int num_errors = 0, checks = 0, seed = 50;
	csbm_bank_manager csbm_bank_manager_inst (.*);
	csbm_nvm_model csbm_nvm_model_inst (.*);
	always #50 sys_clk = ~sys_clk;
	task automatic wrap_up;
		if (num_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : check
	task automatic settle;
		int n;
		n = 0;
		@(negedge sys_clk);
		while (busy !== 1'b0 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		check(n < 1000, "stuck busy");
	endtask : settle
	task automatic cmd(input logic store, input logic refused);
		exp_q.push_back({refused, live_exp});
		@(negedge sys_clk);
		if (store) bank_store_cmd = 1'b1;
		else bank_restore_cmd = 1'b1;
		@(negedge sys_clk);
		bank_store_cmd = 1'b0;
		bank_restore_cmd = 1'b0;
		settle();
	endtask : cmd
	task automatic fill;
		for (int i = 0; i < CSBM_NPARAM; i++) begin
			@(negedge sys_clk);
			param_we = 1'b1;
			param_idx = 6'(i);
			param_wdata = $random(seed);
			live_exp[i*32 +: 32] = param_wdata;
		end
		@(negedge sys_clk) param_we = 1'b0;
		@(negedge sys_clk);
		check(param_rdata === live_exp[36*32 +: 32], "readback");
	endtask : fill
	task automatic sel(input csbm_bank_t b);
		@(negedge sys_clk);
		bank_select_we = 1'b1;
		bank_select_wdata = b;
		boot_bank_select_we = 1'b1;
		boot_bank_select_wdata = b;
		@(negedge sys_clk);
		bank_select_we = 1'b0;
		boot_bank_select_we = 1'b0;
	endtask : sel
	// Results are compared in arrival order, one note per command
	always @(negedge sys_clk) begin
		if (!reset && (cmd_done === 1'b1 || cmd_refused === 1'b1)) begin
			if (exp_q.size() == 0) check(1'b0, "unexpected result");
			else check({cmd_refused, live_params} === exp_q.pop_front(), "result");
		end
	end
	initial begin
		for (int i = 0; i < CSBM_NPARAM; i++) bank_exp[0][i*32 +: 32] = 32'hf000_0000 + i;
		live_exp = '0;
		repeat (20) @(negedge sys_clk);
		reset = 1'b0;
		settle();
		check(bank_select === CSBM_BANK_FACTORY && live_params === live_exp, "reset");
		cmd(1'b1, 1'b1);
		for (int b = 1; b < 4; b++) begin
			fill();
			bank_exp[b] = live_exp;
			sel(csbm_bank_t'(b));
			slow = b[0];
			cmd(1'b1, 1'b0);
		end
		for (int b = 0; b < 4; b++) begin
			fill();
			sel(csbm_bank_t'(b));
			stream_active = 1'b1;
			cmd(1'b0, 1'b1);
			stream_active = 1'b0;
			live_exp = bank_exp[b];
			cmd(1'b0, 1'b0);
		end
		reset = 1'b1;
		repeat (20) @(negedge sys_clk);
		reset = 1'b0;
		settle();
		check(boot_bank_select === CSBM_BANK_THREE && live_params === bank_exp[3], "boot");
		wrap_up();
	end
	initial begin
		#2000000;
		num_errors++;
		wrap_up();
	end
endmodule : csbm_bank_manager_tb
`default_nettype wire
